// >>> spic_defs.vh
// Constants for the serial peripheral control block
`ifndef SPIC_DEFS_VH
`define SPIC_DEFS_VH
`define SPIC_BITS 8
`define SPIC_CNT_W 4
`define SPIC_BIT_CAPTURE 4'h7
`define SPIC_RATE_DIV0 8'h01
`define SPIC_RATE_DIV1 8'h03
`define SPIC_RATE_DIV2 8'h0f
`define SPIC_RATE_DIV3 8'h1f
`define SPIC_RST_MASTER 1'b1
`define SPIC_RST_CPHA 1'b1
`endif

// >>> spic_buf2.v
// Two-entry valid/ready buffer for received bytes
`timescale 1ns/1ps
module spic_buf2 (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [7:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output reg [7:0] outData
);
  reg [7:0] slot1;
  reg [1:0] count;
  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  always @(posedge sys_clk) begin
    if (rst) begin
      count <= 2'h0;
      outData <= 8'h00;
      slot1 <= 8'h00;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count == 2'h0) outData <= inData;
          else slot1 <= inData;
          count <= count + 2'h1;
        end
        2'b01: begin
          outData <= slot1;
          count <= count - 2'h1;
        end
        2'b11: begin
          if (count == 2'h1) outData <= inData;
          else begin
            outData <= slot1;
            slot1 <= inData;
          end
        end
        default: count <= count;
      endcase
    end
  end
endmodule // spic_buf2

// >>> spic_core.v
// Serial peripheral core: flags, requests, partial reset and pin ownership
`timescale 1ns/1ps
`include "spic_defs.vh"
module spic_core (
  // Clock and reset
  input wire sys_clk,
  input wire rst,

  // Control bits
  input wire moduleEnableIn,
  input wire moduleEnableWr,
  input wire masterSelectBit,
  input wire clockPolarity,
  input wire clockPhase,
  input wire wiredOrSelect,
  input wire txIrqEnable,
  input wire rxIrqEnable,
  input wire errorIrqEnable,
  input wire faultDetectEnable,
  input wire rateSelectHi,
  input wire rateSelectLo,

  // Processor access strobes
  input wire statusRead,
  input wire dataRead,
  input wire controlWrite,
  input wire dataWrite,
  input wire [7:0] dataWriteValue,
  output wire [7:0] rxData,

  // System states
  input wire breakActive,
  input wire breakClearEnable,
  input wire stopMode,

  // Flags and requests
  output wire moduleEnableBit,
  output wire dmaSelectBit,
  output reg txEmptyFlag,
  output reg rxFullFlag,
  output reg overrunFlag,
  output reg modeFaultFlag,
  output reg txIrq,
  output reg rxErrIrq,

  // Serial pins
  input wire misoIn,
  output reg misoOut,
  output reg misoOe,
  input wire mosiIn,
  output reg mosiOut,
  output reg mosiOe,
  input wire sckIn,
  output reg sckOut,
  output reg sckOe,
  input wire slaveSelectNIn,
  output wire portOwned,

  // Received byte stream toward a consumer
  output wire rxStreamValid,
  input wire rxStreamReady,
  output wire [7:0] rxStreamData
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [2:0] sckSync, ssSync, misoSync, mosiSync;
  reg sckStable, ssStable;
  always @(posedge sys_clk) begin
    if (rst) begin
      sckSync <= 3'h0;
      ssSync <= 3'h7;
      misoSync <= 3'h0;
      mosiSync <= 3'h0;
      sckStable <= 1'b0;
      ssStable <= 1'b1;
    end else begin
      sckSync <= {sckSync[1:0], sckIn};
      ssSync <= {ssSync[1:0], slaveSelectNIn};
      misoSync <= {misoSync[1:0], misoIn};
      mosiSync <= {mosiSync[1:0], mosiIn};

      // A change counts once the last two stages agree
      if (sckSync[1] == sckSync[2]) sckStable <= sckSync[2];
      if (ssSync[1] == ssSync[2]) ssStable <= ssSync[2];
    end
  end

  // Data pins are read after the third stage, at a known point of the frame
  wire misoS = misoSync[2];
  wire mosiS = mosiSync[2];

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  reg enable;
  reg stsSawRx, stsSawOvr, stsSawFault;
  reg [7:0] shifter, txHold, rxHold;
  reg txHoldFull, active, sckLevel, sckPrev;
  reg [3:0] edgeCnt;
  reg [7:0] divCnt;

  wire frozen = breakActive && !breakClearEnable;
  wire halted = stopMode;
  wire isMaster = enable && masterSelectBit;
  wire isSlave = enable && !masterSelectBit;

  assign moduleEnableBit = enable;
  assign dmaSelectBit = 1'b0;
  assign portOwned = enable;
  wire faultNow = faultDetectEnable && enable &&
                  ((masterSelectBit && !ssStable) || (!masterSelectBit && active && ssStable));

  // Rate divider for master clocking
  function [7:0] rateDiv;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: rateDiv = `SPIC_RATE_DIV0;
        2'h1: rateDiv = `SPIC_RATE_DIV1;
        2'h2: rateDiv = `SPIC_RATE_DIV2;
        default: rateDiv = `SPIC_RATE_DIV3;
      endcase
    end
  endfunction
  wire rateTick = (divCnt == rateDiv({rateSelectHi, rateSelectLo}));

  // Serial clock edges: leading and trailing relative to idle polarity
  wire slvEdge = sckStable != sckPrev;
  wire mstEdge = isMaster && active && rateTick;
  wire edgeNow = isMaster ? mstEdge : (isSlave && !ssStable && slvEdge);
  wire leading = edgeNow && (edgeCnt[0] == 1'b0);
  wire sampleEdge = edgeNow && (leading ^ clockPhase);
  wire shiftEdge = edgeNow && !(leading ^ clockPhase);
  wire lastEdge = edgeNow && (edgeCnt == 4'hf);

  // Sampling and shifting sit on opposite edges, so the outgoing bit
  // never changes on the edge at which the partner samples it
  wire rxIn = masterSelectBit ? misoS : mosiS;
  reg rxBit;
  wire [7:0] nextShifter = {shifter[6:0], clockPhase ? rxIn : rxBit};
  wire [7:0] shiftedIn = {shifter[6:0], rxBit};

  // With phase 1 the first leading edge only opens the frame: the top bit
  // already stands on the line since the load
  wire shiftNow = shiftEdge && !(clockPhase && edgeCnt == 4'h0);

  // Bit 1 is captured in the seventh serial clock cycle:
  // edge 12 with phase 0, edge 13 with phase 1
  wire [3:0] captureCnt = ((`SPIC_BIT_CAPTURE - 4'h1) << 1) | {3'h0, clockPhase};

  // Buffer toward the receive side; a full buffer holds off the start of the next transfer
  wire bufReady;
  wire moveToRx = lastEdge && !overrunFlag && !rxFullFlag;
  spic_buf2 rxBuffer (
    .sys_clk(sys_clk),
    .rst(rst),
    .inValid(moveToRx),
    .inReady(bufReady),
    .inData(nextShifter),
    .outValid(rxStreamValid),
    .outReady(rxStreamReady),
    .outData(rxStreamData)
  );

  assign rxData = rxHold;
  wire txAccept = dataWrite && !frozen;
  wire startOk = txHoldFull && !active && !overrunFlag && bufReady &&
                 (isMaster || (isSlave && !ssStable));

  // ----------------------------------------
  // Transfer engine
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst || !enable) begin
      shifter <= 8'h00;
      edgeCnt <= 4'h0;
      active <= 1'b0;
      sckLevel <= 1'b0;
      divCnt <= 8'h00;
      rxBit <= 1'b0;
      sckPrev <= sckStable;
      txHoldFull <= rst ? 1'b0 : txHoldFull && 1'b0;
      txHold <= rst ? 8'h00 : txHold;
      rxHold <= rst ? 8'h00 : rxHold;
    end else if (!halted) begin
      sckPrev <= sckStable;
      divCnt <= (rateTick || !active) ? 8'h00 : divCnt + 8'h01;

      if (txAccept) begin
        txHold <= dataWriteValue;
        txHoldFull <= 1'b1;
      end

      if (startOk && !txAccept) begin
        shifter <= txHold;
        txHoldFull <= 1'b0;
        active <= 1'b1;
        edgeCnt <= 4'h0;
      end else if (active) begin
        if (isSlave && ssStable) active <= 1'b0;
        if (edgeNow) begin
          edgeCnt <= edgeCnt + 4'h1;
          if (isMaster) sckLevel <= ~sckLevel;
        end
        if (sampleEdge) rxBit <= rxIn;
        if (shiftNow) shifter <= shiftedIn;
        if (lastEdge) begin
          active <= 1'b0;
          if (moveToRx) rxHold <= nextShifter;
        end
      end
    end
  end

  // ----------------------------------------
  // Enable bit and flags
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      enable <= 1'b0;
      txEmptyFlag <= 1'b1;
      rxFullFlag <= 1'b0;
      overrunFlag <= 1'b0;
      modeFaultFlag <= 1'b0;
      stsSawRx <= 1'b0;
      stsSawOvr <= 1'b0;
      stsSawFault <= 1'b0;
    end else begin

      if (moduleEnableWr) enable <= moduleEnableIn;
      if (faultNow && masterSelectBit) enable <= 1'b0;

      // Status snapshot for two-step clears; frozen during protected break
      if (statusRead && !frozen) begin
        stsSawRx <= rxFullFlag;
        stsSawOvr <= overrunFlag;
        stsSawFault <= modeFaultFlag;
      end

      // Clears first, sets after, so a simultaneous event wins
      if (dataRead && stsSawRx && !frozen) begin
        rxFullFlag <= 1'b0;
        stsSawRx <= 1'b0;
      end

      if (dataRead && stsSawOvr && !frozen) begin
        overrunFlag <= 1'b0;
        stsSawOvr <= 1'b0;
      end

      if (controlWrite && stsSawFault && !faultNow && !frozen) begin
        modeFaultFlag <= 1'b0;
        stsSawFault <= 1'b0;
      end
      if (faultNow) stsSawFault <= 1'b0;

      if (txAccept) txEmptyFlag <= 1'b0;
      if (!enable || (startOk && !txAccept && !halted)) txEmptyFlag <= 1'b1;
      if (moveToRx && enable && !halted) rxFullFlag <= 1'b1;

      if (edgeNow && sampleEdge && edgeCnt == captureCnt && rxFullFlag && !halted)
        overrunFlag <= 1'b1;
      if (faultNow && !halted) modeFaultFlag <= 1'b1;
    end
  end

  // ----------------------------------------
  // Requests and pins
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      txIrq <= 1'b0;
      rxErrIrq <= 1'b0;
      misoOut <= 1'b0;
      misoOe <= 1'b0;
      mosiOut <= 1'b0;
      mosiOe <= 1'b0;
      sckOut <= 1'b0;
      sckOe <= 1'b0;
    end else begin
      // Levels that also wake the processor from wait
      txIrq <= txEmptyFlag && txIrqEnable && enable && !dmaSelectBit;
      rxErrIrq <= (rxFullFlag && rxIrqEnable) ||
                  (errorIrqEnable && (overrunFlag || modeFaultFlag));

      misoOut <= shifter[7];
      misoOe <= isSlave && !ssStable;

      // Open-drain mosi only pulls low
      mosiOut <= wiredOrSelect ? 1'b0 : shifter[7];
      mosiOe <= isMaster && (!wiredOrSelect || !shifter[7]);

      // Launched with the edge decision itself: a copy of the level one cycle
      // later would cost the partner's data a cycle of set-up before sampling
      sckOut <= ((mstEdge && !halted) ? ~sckLevel : sckLevel) ^ clockPolarity;
      sckOe <= isMaster;
    end
  end
endmodule // spic_core

// >>> spic_core_props.sv
// Checker for the serial peripheral core
`timescale 1ns/1ps
module spic_core_props (
  // Clock and reset
  input logic sys_clk,
  input logic rst,
  // Control and strobes
  input logic txIrqEnable,
  input logic rxIrqEnable,
  input logic errorIrqEnable,
  input logic faultDetectEnable,
  input logic masterSelectBit,
  input logic breakActive,
  input logic breakClearEnable,
  input logic dataRead,
  input logic dataWrite,
  input logic controlWrite,
  // Flags, requests and pins
  input logic moduleEnableBit,
  input logic dmaSelectBit,
  input logic txEmptyFlag,
  input logic rxFullFlag,
  input logic overrunFlag,
  input logic modeFaultFlag,
  input logic txIrq,
  input logic rxErrIrq,
  input logic mosiOe,
  input logic sckOe,
  input logic misoOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_tx_gate: assert property (txIrq == $past(txEmptyFlag && txIrqEnable && moduleEnableBit && !dmaSelectBit))
    else $error("tx request mismatch");
  a_rx_gate: assert property (rxErrIrq == $past(rxFullFlag && rxIrqEnable || errorIrqEnable && (overrunFlag || modeFaultFlag)))
    else $error("rx request mismatch");
  a_fault_gate: assert property (!faultDetectEnable && !modeFaultFlag |=> !modeFaultFlag)
    else $error("fault set while detection off");
  a_off_state: assert property (!moduleEnableBit [*2] |-> txEmptyFlag && !mosiOe && !sckOe && !misoOe)
    else $error("disabled block still active");
  a_break_hold: assert property (breakActive && !breakClearEnable && txEmptyFlag |=> txEmptyFlag)
    else $error("tx empty changed in break");
  a_master_fault: assert property ($rose(modeFaultFlag) && $past(masterSelectBit) |-> !moduleEnableBit)
    else $error("fault left block enabled");
  a_tx_clear: assert property ($fell(txEmptyFlag) |-> $past(dataWrite))
    else $error("tx empty cleared without write");
  a_rx_clear: assert property ($fell(rxFullFlag) |-> $past(dataRead))
    else $error("rx full cleared without read");
  a_ovr_clear: assert property ($fell(overrunFlag) |-> $past(dataRead))
    else $error("overrun cleared without read");
  a_fault_clear: assert property ($fell(modeFaultFlag) |-> $past(controlWrite))
    else $error("fault cleared without write");
endmodule // spic_core_props
bind spic_core spic_core_props i_props (.*);

// >>> spic_far_slave.sv
// Slave model on the serial side
`timescale 1ns/1ps
module spic_far_slave (
  // Serial pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic ssN,
  output logic miso
);
  logic [7:0] tx = 8'h3c;
  logic [7:0] sr;
  logic [7:0] got;
  int nb = 0;
  int bits = 0;
  logic armed = 1'b0;
  initial miso = 1'b0;
  // Leading edge launches the next bit, MSB first
  always @(posedge sck) if (!ssN) begin
    miso <= tx[7 - bits];
    armed <= 1'b1;
  end
  // Trailing edge samples; eight clock cycles make one byte
  // A fall with no rise before it (the line settling at start-up) is no bit
  always @(negedge sck) if (!ssN && armed) begin
    armed <= 1'b0;
    sr = {sr[6:0], mosi};
    bits = bits + 1;
    if (bits == 8) begin
      got = sr;
      nb = nb + 1;
      tx = tx + 8'h01;
      bits = 0;
    end
  end
endmodule // spic_far_slave

// >>> test_spic_core.sv
// Testbench for the serial peripheral core
`timescale 1ns/1ps
module test_spic_core;
  logic sys_clk, rst, moduleEnableIn, moduleEnableWr, masterSelectBit, clockPolarity, clockPhase, wiredOrSelect;
  logic txIrqEnable, rxIrqEnable, errorIrqEnable, faultDetectEnable, rateSelectHi, rateSelectLo;
  logic statusRead, dataRead, controlWrite, dataWrite, breakActive, breakClearEnable, stopMode;
  logic slaveSelectNIn, rxStreamReady, farMiso;
  logic [7:0] dataWriteValue, rxData, rxStreamData;
  logic moduleEnableBit, dmaSelectBit, txEmptyFlag, rxFullFlag, overrunFlag, modeFaultFlag, txIrq, rxErrIrq;
  logic misoOut, misoOe, mosiOut, mosiOe, sckOut, sckOe, portOwned, rxStreamValid;
  // Line levels: pull-up on mosi, miso from the far slave, clock idles low when undriven
  wire misoIn = misoOe ? misoOut : farMiso;
  wire mosiIn = mosiOe ? mosiOut : 1'b1;
  wire sckIn = sckOe ? sckOut : 1'b0;
  int miscompares = 0;
  int n_checks = 0;
  int n0;
  logic [5:0] rows [4] = '{6'h00, 6'h10, 6'h32, 6'h2c};
  spic_core i_dut (.*);
  spic_far_slave i_far (.sck(sckIn), .mosi(mosiIn), .ssN(1'b0), .miso(farMiso));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task strobe(input logic [3:0] s);
    @(posedge sys_clk) {statusRead, dataRead, controlWrite, dataWrite} <= s;
    @(posedge sys_clk) {statusRead, dataRead, controlWrite, dataWrite} <= 4'h0;
    cyc(2);
  endtask
  task en(input logic v);
    @(posedge sys_clk) {moduleEnableIn, moduleEnableWr} <= {v, 1'b1};
    @(posedge sys_clk) moduleEnableWr <= 1'b0;
  endtask
  task waitb;
    repeat (3000) if (i_far.nb == n0) @(posedge sys_clk);
    cyc(40);
  endtask
  task xfer(input logic [7:0] d);
    @(posedge sys_clk) dataWriteValue <= d;
    n0 = i_far.nb;
    strobe(4'h1);
    waitb;
  endtask
  task pop;
    @(posedge sys_clk) rxStreamReady <= 1'b1;
    @(posedge sys_clk) rxStreamReady <= 1'b0;
    cyc(2);
  endtask
  task complete_run;
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #400000;
    miscompares++;
    complete_run;
  end
  initial begin
    {moduleEnableIn, moduleEnableWr, clockPolarity, wiredOrSelect, txIrqEnable, rxIrqEnable, errorIrqEnable} = '0;
    {faultDetectEnable, rateSelectHi, statusRead, dataRead, controlWrite, dataWrite, breakActive} = '0;
    {breakClearEnable, stopMode, rxStreamReady, dataWriteValue} = '0;
    {rst, masterSelectBit, clockPhase, rateSelectLo, slaveSelectNIn} = '1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(2);
    chk({moduleEnableBit, txEmptyFlag, rxFullFlag, overrunFlag, modeFaultFlag, mosiOe, sckOe, misoOe, txIrq, rxErrIrq}, 16'h100);
    foreach (rows[i]) begin
      en(rows[i][5]);
      @(posedge sys_clk) {txIrqEnable, rxIrqEnable, errorIrqEnable} <= rows[i][4:2];
      cyc(4);
      chk({dmaSelectBit, txIrq, rxErrIrq}, rows[i][1:0]);
    end
    xfer(8'ha5);
    chk({i_far.got, rxFullFlag, rxErrIrq}, {8'ha5, 2'h3});
    en(1'b0);
    cyc(3);
    chk({rxFullFlag, rxErrIrq, txEmptyFlag, mosiOe, sckOe, portOwned}, 6'h38);
    strobe(4'h8);
    strobe(4'h4);
    chk({rxFullFlag, rxData}, {1'b0, 8'h3c});
    // Fill the receive buffer until it refuses a new transfer
    en(1'b1);
    xfer(8'h5a);
    n0 = i_far.nb;
    strobe(4'h1);
    cyc(300);
    chk({rxStreamValid, rxStreamData, i_far.nb == n0}, {1'b1, 8'h3c, 1'b1});
    @(posedge sys_clk) rxIrqEnable <= 1'b0;
    pop;
    chk({rxStreamValid, rxStreamData}, {1'b1, 8'h3d});
    pop;
    chk(rxStreamValid, 1'b0);
    // Pending byte now lands on unread data
    waitb;
    chk({overrunFlag, rxErrIrq}, 2'h3);
    strobe(4'h8);
    strobe(4'h4);
    chk({overrunFlag, rxFullFlag}, 2'h0);
    @(posedge sys_clk) breakActive <= 1'b1;
    n0 = i_far.nb;
    strobe(4'h1);
    cyc(200);
    chk({txEmptyFlag, i_far.nb == n0}, 2'h3);
    @(posedge sys_clk) breakActive <= 1'b0;
    @(posedge sys_clk) slaveSelectNIn <= 1'b0;
    cyc(10);
    chk({modeFaultFlag, moduleEnableBit}, 2'h1);
    @(posedge sys_clk) faultDetectEnable <= 1'b1;
    cyc(10);
    chk({modeFaultFlag, moduleEnableBit, txEmptyFlag, rxErrIrq}, 4'hb);
    strobe(4'h8);
    // A new fault between the two steps cancels the clear
    en(1'b1);
    cyc(4);
    strobe(4'h2);
    chk(modeFaultFlag, 1'b1);
    @(posedge sys_clk) slaveSelectNIn <= 1'b1;
    cyc(6);
    strobe(4'h8);
    strobe(4'h2);
    chk(modeFaultFlag, 1'b0);
    // Stop mid-frame: the clock holds still and the frame ends after release
    en(1'b1);
    @(posedge sys_clk) dataWriteValue <= 8'h69;
    n0 = i_far.nb;
    strobe(4'h1);
    @(posedge sys_clk) stopMode <= 1'b1;
    cyc(200);
    chk({i_far.nb == n0, txEmptyFlag, sckOut}, 3'h6);
    @(posedge sys_clk) stopMode <= 1'b0;
    waitb;
    chk(i_far.nb == n0 + 1, 1'b1);
    chk(i_far.got, 8'h69);
    @(posedge sys_clk) {breakActive, breakClearEnable} <= 2'h3;
    strobe(4'h8);
    strobe(4'h4);
    @(posedge sys_clk) {breakActive, breakClearEnable} <= 2'h0;
    cyc(4);
    chk({rxFullFlag, rxData}, {1'b0, 8'h3f});
    complete_run;
  end
endmodule // test_spic_core
